// [verilog/hbridge_decay_fault_control.sv]
`timescale 1ns/10ps
// Contract
// - Forward direction gate patterns per mode
// - Reverse direction gate patterns per mode
// - Dead time before arriving switches turn on
// - Autonomous charge, fast, slow sequencing
// - Chopping period is sixteen oscillator clocks
// - Default oscillator when no resistor fitted
// - Overheat accepted after 5 us persistence
// - Overheat turns off every output
// - Overcurrent after 1.25 us forces outputs off
// - Both shutdowns latched until recovery
// - Cleared only by power or sleep cycle
// - Undervoltage forces off and resets logic
// - Fast decay lasts six oscillator clocks
// - General flag low on overheat or overcurrent, not on undervoltage
// - Thermal flag low on overheat only
module hbridge_decay_fault_control (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             irq_o,
    input  wire logic        overheat_fault_i,
    input  wire logic        overcurrent_fault_i,
    input  wire logic        supply_undervoltage_i,
    input  wire logic        current_reached_i,
    input  wire logic        chop_osc_pin_fitted_i,
    output logic             high_side_first_o,
    output logic             high_side_second_o,
    output logic             low_side_first_o,
    output logic             low_side_second_o,
    output logic             fault_flag_general_o,
    output logic             fault_flag_general_oe_n_o,
    output logic             fault_flag_thermal_o,
    output logic             fault_flag_thermal_oe_n_o
);
    import hbridge_pkg::*;

    typedef struct packed {
        logic [4:0]  s1;
        logic [4:0]  s2;
        logic [4:0]  s3;
        logic [4:0]  inp;
        logic [6:0]  ot_cnt;
        logic [4:0]  oc_cnt;
        logic        ot_lat;
        logic        oc_lat;
        logic [15:0] osc_cnt;
        logic        tick;
        logic [3:0]  ph;
        mode_t       mode;
        logic [2:0]  fast_cnt;
        logic        dir;
        logic        sleep;
        logic [15:0] div;
        logic [2:0]  ev;
        logic [2:0]  mask;
        logic        ack;
        logic [31:0] dat;
        logic        irq;
        logic        gen_oe_n;
        logic        th_oe_n;
        logic        force_off;
        logic [3:0]  req;
    } core_t;

    core_t       s_r;
    core_t       s_nxt;
    logic        bus_req;
    logic        bus_do;
    logic        ev_clr;
    logic        ot_set;
    logic        oc_set;
    logic [15:0] per;
    logic        wrap;
    gate_if      gi ();

    always_comb begin
        s_nxt = s_r;
        ev_clr = 1'b0;
        ot_set = 1'b0;
        oc_set = 1'b0;
        // Pins: three stages, a change counts when stages two and three agree
        s_nxt.s1 = {chop_osc_pin_fitted_i, current_reached_i, supply_undervoltage_i,
                    overcurrent_fault_i, overheat_fault_i};
        s_nxt.s2 = s_r.s1;
        s_nxt.s3 = s_r.s2;
        for (int i = 0; i < 5; i++) begin
            if (s_r.s2[i] == s_r.s3[i]) begin
                s_nxt.inp[i] = s_r.s3[i];
            end
        end

        // Bus: ack one cycle after the request, write and clear on the ack edge
        bus_req = wb_cyc_i && wb_stb_i && !s_r.ack;
        bus_do  = wb_cyc_i && wb_stb_i && s_r.ack;
        s_nxt.ack = bus_req;
        s_nxt.dat = 32'h0;
        if (bus_req) begin
            case (wb_adr_i)
                ADR_CTRL: s_nxt.dat = {30'h0, s_r.sleep, s_r.dir};
                ADR_DIV:  s_nxt.dat = {16'h0, s_r.div};
                ADR_STAT: s_nxt.dat = {26'h0, s_r.mode, s_r.inp[IN_FIT], s_r.inp[IN_UV],
                                       s_r.oc_lat, s_r.ot_lat};
                ADR_IRQ:  s_nxt.dat = {29'h0, s_r.ev};
                ADR_MASK: s_nxt.dat = {29'h0, s_r.mask};
                default:  s_nxt.dat = 32'h0;
            endcase
        end
        if (bus_do) begin
            case (wb_adr_i)
                ADR_CTRL: begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.dir   = wb_dat_i[CTRL_DIR];
                        s_nxt.sleep = wb_dat_i[CTRL_SLEEP];
                    end
                end
                ADR_DIV: begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.div[7:0] = wb_dat_i[7:0];
                    end
                    if (wb_we_i && wb_sel_i[1]) begin
                        s_nxt.div[15:8] = wb_dat_i[15:8];
                    end
                end
                ADR_IRQ:  ev_clr = !wb_we_i;
                ADR_MASK: begin
                    if (wb_we_i && wb_sel_i[0]) begin
                        s_nxt.mask = wb_dat_i[2:0];
                    end
                end
                default: ev_clr = 1'b0;
            endcase
        end

        // Deglitch: a drop of the filtered input restarts the count
        if (s_r.inp[IN_OT]) begin
            if (s_r.ot_cnt == 7'(OT_CYC - 1)) begin
                ot_set = 1'b1;
            end else begin
                s_nxt.ot_cnt = s_r.ot_cnt + 7'h1;
            end
        end else begin
            s_nxt.ot_cnt = 7'h0;
        end
        if (s_r.inp[IN_OC]) begin
            if (s_r.oc_cnt == 5'(OC_CYC - 1)) begin
                oc_set = 1'b1;
            end else begin
                s_nxt.oc_cnt = s_r.oc_cnt + 5'h1;
            end
        end else begin
            s_nxt.oc_cnt = 5'h0;
        end
        // Set wins over the sleep clear
        s_nxt.ot_lat = ot_set || (s_r.ot_lat && !s_r.sleep);
        s_nxt.oc_lat = oc_set || (s_r.oc_lat && !s_r.sleep);

        // Oscillator timebase; a divider of zero stops the chopper
        per = s_r.inp[IN_FIT] ? s_r.div : 16'(OSC_DEF_CYC);
        s_nxt.tick = 1'b0;
        if (per == 16'h0) begin
            s_nxt.osc_cnt = 16'h0;
        end else if (s_r.osc_cnt >= per - 16'h1) begin
            s_nxt.osc_cnt = 16'h0;
            s_nxt.tick    = 1'b1;
        end else begin
            s_nxt.osc_cnt = s_r.osc_cnt + 16'h1;
        end

        // Chopper sequencing, one step per oscillator clock
        wrap = (s_r.ph == 4'(CHOP_DIV - 1));
        if (s_r.tick) begin
            s_nxt.ph = s_r.ph + 4'h1;
            case (s_r.mode)
                M_OFF: begin
                    if (wrap) begin
                        s_nxt.mode = M_CHARGE;
                    end
                end
                M_CHARGE: begin
                    // Charge may run past a cycle boundary until current is reached
                    if (s_r.inp[IN_NF]) begin
                        s_nxt.mode     = M_FAST;
                        s_nxt.fast_cnt = 3'h0;
                    end
                end
                M_FAST: begin
                    if (s_r.fast_cnt == 3'(FAST_CLKS - 1)) begin
                        s_nxt.mode = M_SLOW;
                    end else begin
                        s_nxt.fast_cnt = s_r.fast_cnt + 3'h1;
                    end
                end
                M_SLOW: begin
                    if (wrap) begin
                        s_nxt.mode = M_CHARGE;
                    end
                end
                default: s_nxt.mode = M_OFF;
            endcase
        end

        // Undervoltage holds the core in reset, bus registers keep their values
        if (s_nxt.inp[IN_UV]) begin
            s_nxt.ot_cnt   = 7'h0;
            s_nxt.oc_cnt   = 5'h0;
            s_nxt.ot_lat   = 1'b0;
            s_nxt.oc_lat   = 1'b0;
            s_nxt.osc_cnt  = 16'h0;
            s_nxt.tick     = 1'b0;
            s_nxt.ph       = 4'h0;
            s_nxt.fast_cnt = 3'h0;
        end
        s_nxt.force_off = s_nxt.ot_lat || s_nxt.oc_lat || s_nxt.inp[IN_UV] || s_nxt.sleep;
        if (s_nxt.force_off) begin
            s_nxt.mode = M_OFF;
        end
        s_nxt.req = gate_pattern(s_nxt.mode, s_nxt.dir);
        s_nxt.gen_oe_n = !(s_nxt.ot_lat || s_nxt.oc_lat);
        s_nxt.th_oe_n  = !s_nxt.ot_lat;

        s_nxt.ev = (ev_clr ? 3'h0 : s_r.ev) |
                   {s_nxt.inp[IN_UV] && !s_r.inp[IN_UV],
                    oc_set && !s_r.oc_lat, ot_set && !s_r.ot_lat};
        s_nxt.irq = |(s_nxt.ev & s_nxt.mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r           <= '0;
            s_r.div       <= DIV_RST;
            s_r.gen_oe_n  <= 1'b1;
            s_r.th_oe_n   <= 1'b1;
            s_r.force_off <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gi.req       = s_r.req;
    assign gi.force_off = s_r.force_off;

    gate_dead_time u_dead (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .gi    (gi.drv)
    );

    assign wb_dat_o                  = s_r.dat;
    assign wb_ack_o                  = s_r.ack;
    assign irq_o                     = s_r.irq;
    assign high_side_first_o         = gi.gates[3];
    assign high_side_second_o        = gi.gates[2];
    assign low_side_first_o          = gi.gates[1];
    assign low_side_second_o         = gi.gates[0];
    // Open-drain flags only ever pull low
    assign fault_flag_general_o      = 1'b0;
    assign fault_flag_thermal_o      = 1'b0;
    assign fault_flag_general_oe_n_o = s_r.gen_oe_n;
    assign fault_flag_thermal_oe_n_o = s_r.th_oe_n;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_fault_gates_off: assert property ((s_r.ot_lat || s_r.oc_lat) |=> gi.gates == 4'h0)
        else $error("Gates on during latched fault");
    a_ot_persist: assert property ($rose(s_r.ot_lat) |-> $past(s_r.ot_cnt) == 7'(OT_CYC - 1))
        else $error("Overheat latched before persistence");
    a_oc_persist: assert property ($rose(s_r.oc_lat) |-> $past(s_r.oc_cnt) == 5'(OC_CYC - 1))
        else $error("Overcurrent latched before persistence");
    a_latch_holds: assert property (s_r.ot_lat && !s_r.sleep && !s_nxt.inp[IN_UV]
                                    |=> s_r.ot_lat)
        else $error("Overheat latch released without recovery");
    a_sleep_clears: assert property (s_r.sleep && !s_r.inp[IN_OC] |=> !s_r.oc_lat)
        else $error("Sleep did not clear overcurrent latch");
    a_uv_off: assert property (s_r.inp[IN_UV] |-> s_r.mode == M_OFF && !s_r.ot_lat
                               ##1 gi.gates == 4'h0)
        else $error("Outputs active during undervoltage");
    a_fast_length: assert property (s_r.mode == M_FAST && s_nxt.mode == M_SLOW
                                    |-> s_r.fast_cnt == 3'(FAST_CLKS - 1) && s_r.tick)
        else $error("Fast decay length wrong");
    a_chop_wrap: assert property (s_r.tick && wrap && !s_nxt.inp[IN_UV]
                                  |=> s_r.ph == 4'h0)
        else $error("Chopping cycle not sixteen clocks");
    a_default_osc: assert property (s_r.tick && !s_r.inp[IN_FIT] && $past(!s_r.inp[IN_FIT])
                                    && $past(!s_r.inp[IN_FIT], 2)
                                    |-> $past(s_r.osc_cnt) == 16'(OSC_DEF_CYC - 1))
        else $error("Default oscillator period wrong");
    a_flag_general: assert property ((s_r.ot_lat || s_r.oc_lat) == !s_r.gen_oe_n)
        else $error("General flag mismatch");
    a_flag_thermal: assert property (s_r.oc_lat && !s_r.ot_lat |-> s_r.th_oe_n)
        else $error("Thermal flag driven on overcurrent");
    a_gate_pattern: assert property (!s_r.force_off |-> s_r.req ==
        ((s_r.mode == M_CHARGE) ? (s_r.dir ? 4'h6 : 4'h9) :
         (s_r.mode == M_FAST)   ? (s_r.dir ? 4'h9 : 4'h6) :
         (s_r.mode == M_SLOW)   ? 4'h3 : 4'h0))
        else $error("Gate pattern wrong for mode");

    c_ot_latch: cover property ($rose(s_r.ot_lat));
    c_fast_to_slow: cover property (s_r.mode == M_FAST ##1 s_r.mode == M_SLOW);
    c_long_charge: cover property (s_r.mode == M_CHARGE && s_r.tick && wrap);
    c_irq_clear: cover property (s_r.irq ##1 ev_clr);
endmodule

// [verilog/hbridge_pkg.sv]
package hbridge_pkg;
    localparam int CLK_HZ      = 20_000_000;
    localparam int CLK_NS      = 1_000_000_000 / CLK_HZ;
    // Default oscillator when no timing resistor is fitted
    localparam int OSC_DEF_KHZ = 914;
    localparam int OSC_DEF_CYC = (CLK_HZ / 1000) / OSC_DEF_KHZ;
    localparam int CHOP_DIV    = 16;
    localparam int FAST_CLKS   = 6;
    localparam int OT_NS       = 5000;
    localparam int OT_CYC      = (OT_NS + CLK_NS - 1) / CLK_NS;
    localparam int OC_NS       = 1250;
    localparam int OC_CYC      = (OC_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEAD_NS     = 500;
    localparam int DEAD_CYC    = (DEAD_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [7:0]  ADR_CTRL = 8'h00;
    localparam logic [7:0]  ADR_DIV  = 8'h04;
    localparam logic [7:0]  ADR_STAT = 8'h08;
    localparam logic [7:0]  ADR_IRQ  = 8'h0c;
    localparam logic [7:0]  ADR_MASK = 8'h10;
    localparam int          CTRL_DIR   = 0;
    localparam int          CTRL_SLEEP = 1;
    localparam logic [15:0] DIV_RST  = 16'h0011;
    localparam int          EV_OT = 0;
    localparam int          EV_OC = 1;
    localparam int          EV_UV = 2;
    // Pin input positions in the synchroniser vector
    localparam int          IN_OT  = 0;
    localparam int          IN_OC  = 1;
    localparam int          IN_UV  = 2;
    localparam int          IN_NF  = 3;
    localparam int          IN_FIT = 4;

    typedef enum logic [1:0] {M_OFF, M_CHARGE, M_FAST, M_SLOW} mode_t;

    // Gate order {high first, high second, low first, low second}
    function automatic logic [3:0] gate_pattern(input mode_t m, input logic rev);
        logic [3:0] g;
        g = 4'h0;
        case (m)
            M_CHARGE: g = rev ? 4'h6 : 4'h9;
            M_FAST:   g = rev ? 4'h9 : 4'h6;
            M_SLOW:   g = 4'h3;
            default:  g = 4'h0;
        endcase
        return g;
    endfunction
endpackage

// [verilog/gate_if.sv]
`timescale 1ns/10ps
interface gate_if;
    logic [3:0] req;
    logic       force_off;
    logic [3:0] gates;
    modport ctrl (output req, output force_off, input gates);
    modport drv  (input req, input force_off, output gates);
endinterface

// [verilog/gate_dead_time.sv]
`timescale 1ns/10ps
module gate_dead_time (
    input  wire logic clk_i,
    input  wire logic rst_i,
    gate_if.drv       gi
);
    import hbridge_pkg::*;

    typedef struct packed {
        logic [3:0] gates;
        logic [3:0] cnt;
    } drv_t;

    drv_t s_r;
    drv_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.cnt = (s_r.cnt != 4'h0) ? s_r.cnt - 4'h1 : 4'h0;
        if (gi.force_off) begin
            // Switching off is always safe, so no gap is waited for
            s_nxt.gates = 4'h0;
            s_nxt.cnt   = 4'(DEAD_CYC);
        end else if (|(s_r.gates & ~gi.req)) begin
            s_nxt.gates = s_r.gates & gi.req;
            s_nxt.cnt   = 4'(DEAD_CYC);
        end else if (s_r.cnt == 4'h0) begin
            s_nxt.gates = gi.req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign gi.gates = s_r.gates;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_leg_exclusive: assert property (!(s_r.gates[3] && s_r.gates[1]) &&
                                      !(s_r.gates[2] && s_r.gates[0]))
        else $error("Both switches of one leg on");
    a_arrive_after_gap: assert property (|(s_r.gates & ~$past(s_r.gates))
                                         |-> $past(s_r.cnt) == 4'h0)
        else $error("Switch turned on inside dead time");
    a_gap_length: assert property ($fell(|s_r.gates) && !$past(gi.force_off)
                                   |-> s_r.cnt == 4'(DEAD_CYC))
        else $error("Dead time not loaded on departure");
endmodule

// [sim/bridge_winding_model.sv]
`timescale 1ns/10ps
module bridge_winding_model #(
    parameter int RISE_CYC = 30
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic dir_i,
    input  wire logic stall_i,
    input  wire logic high_side_first_i,
    input  wire logic high_side_second_i,
    input  wire logic low_side_first_i,
    input  wire logic low_side_second_i,
    output logic      current_reached_o,
    output logic      shoot_through_o
);
    int   charge_cnt_r;
    logic charging;

    // Only the driving diagonal builds current; the other one is fast decay
    assign charging = dir_i ? (high_side_second_i & low_side_first_i)
                            : (high_side_first_i & low_side_second_i);
    assign shoot_through_o = (high_side_first_i & low_side_first_i)
                           | (high_side_second_i & low_side_second_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || !charging) begin
            charge_cnt_r <= 0;
        end else if (charge_cnt_r < RISE_CYC) begin
            charge_cnt_r <= charge_cnt_r + 1;
        end
    end

    // Stall stands for a winding too inductive to reach the set current
    assign current_reached_o = !stall_i && (charge_cnt_r >= RISE_CYC);
endmodule

// [sim/testbench.sv]
`timescale 1ns/10ps
module testbench;
    import hbridge_pkg::*;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, ack, irq_o;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, g;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        ot_f, oc_f, uv_f, reached, fitted, stall, dir, shoot;
    logic        hs1, hs2, ls1, ls2, ff_g, oe_g, ff_t, oe_t;
    int          err_count, total_checks, since_fall;
    logic [3:0]  g_prev;

    hbridge_decay_fault_control uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .irq_o(irq_o),
        .overheat_fault_i(ot_f), .overcurrent_fault_i(oc_f), .supply_undervoltage_i(uv_f),
        .current_reached_i(reached), .chop_osc_pin_fitted_i(fitted),
        .high_side_first_o(hs1), .high_side_second_o(hs2), .low_side_first_o(ls1),
        .low_side_second_o(ls2), .fault_flag_general_o(ff_g), .fault_flag_general_oe_n_o(oe_g),
        .fault_flag_thermal_o(ff_t), .fault_flag_thermal_oe_n_o(oe_t));
    bridge_winding_model winding (.clk_i(clk_i), .rst_i(rst_i), .dir_i(dir), .stall_i(stall),
        .high_side_first_i(hs1), .high_side_second_i(hs2), .low_side_first_i(ls1),
        .low_side_second_i(ls2), .current_reached_o(reached), .shoot_through_o(shoot));
    assign g = {hs1, hs2, ls1, ls2};

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic fail(input string msg);
        err_count++;
        $display("mismatch %0t %s", $time, msg);
        close_out();
    endtask

    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) fail("bus answer missing");
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        xfer(a, 1'b0, 32'h0, q);
        chk(q & m, exp, "register read");
    endtask

    task automatic wait_gates(input logic [3:0] p, output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (g !== p && n < 3000);
        total_checks++;
        if (n >= 3000) fail("gate pattern never seen");
    endtask

    task automatic wait_flag(output int n);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (oe_g !== 1'b0 && n < 500);
        if (n >= 500) fail("fault flag never driven");
    endtask

    task automatic period(output int n);
        int a, b;
        wait_gates(4'h9, a);
        wait_gates(4'h3, a);
        wait_gates(4'h9, a);
        wait_gates(4'h3, a);
        wait_gates(4'h9, b);
        n = a + b;
    endtask

    task automatic set_fault(input bit ot, input logic v);
        if (ot) ot_f <= v;
        else oc_f <= v;
    endtask

    task automatic fault_run(input bit ot, input int need);
        int n;
        for (int k = 0; k < 2; k++) begin
            set_fault(ot, 1'b1);
            repeat (need - 10) @(posedge clk_i);
            set_fault(ot, 1'b0);
            repeat (2) @(posedge clk_i);
        end
        repeat (10) @(posedge clk_i);
        chk(oe_g, 1'b1, "short pulses latched");
        set_fault(ot, 1'b1);
        wait_flag(n);
        chk(n >= need && n <= need + 6, 1'b1, "persistence time");
        repeat (2) @(posedge clk_i);
        chk({g, oe_t, ff_g, ff_t}, {4'h0, !ot, 2'b00}, "outputs at fault");
        chk(irq_o, 1'b0, "masked interrupt");
        set_fault(ot, 1'b0);
        repeat (400) @(posedge clk_i);
        chk({g, oe_g}, 5'h00, "fault not held");
        rd(ADR_STAT, 32'h7, ot ? 32'h1 : 32'h2);
        wr(ADR_MASK, 32'h7);
        repeat (3) @(posedge clk_i);
        chk(irq_o, 1'b1, "interrupt raised");
        rd(ADR_IRQ, 32'h7, ot ? 32'h1 : 32'h2);
        repeat (2) @(posedge clk_i);
        chk(irq_o, 1'b0, "interrupt after read clear");
        wr(ADR_MASK, 32'h0);
        wr(ADR_CTRL, 32'h2);
        repeat (3) @(posedge clk_i);
        chk({g, oe_g, oe_t}, 6'h03, "sleep recovery");
        wr(ADR_CTRL, 32'h0);
        wait_gates(4'h9, n);
    endtask

    // Arriving switches must wait out the dead time after any departure
    always @(posedge clk_i) begin
        if (rst_i) begin
            since_fall = 1000;
        end else begin
            if (shoot === 1'b1) fail("leg shoot-through");
            if (|(g & ~g_prev) && since_fall + 1 < DEAD_CYC) begin
                err_count++;
                $display("mismatch %0t switch on inside dead time", $time);
            end
            since_fall = |(~g & g_prev) ? 0 : since_fall + 1;
        end
        g_prev = g;
    end

    initial begin
        repeat (90000) @(posedge clk_i);
        fail("watchdog expired");
    end

    initial begin
        int n;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i} = {4'h8, 8'h00, 4'h3};
        {wb_dat_i, ot_f, oc_f, uv_f, fitted, stall, dir} = {32'h0, 6'b000_010};
        repeat (4) @(posedge clk_i);
        chk({g, ack, irq_o, oe_g, oe_t}, 8'h03, "outputs in reset");
        rst_i <= 1'b0;
        rd(ADR_CTRL, 32'hffffffff, 32'h0);
        rd(ADR_DIV, 32'h0000ffff, {16'h0, DIV_RST});
        rd(ADR_MASK, 32'hffffffff, 32'h0);
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'hffffffff, 32'h0);
        repeat (800) @(posedge clk_i);
        chk(g, 4'h9, "forward charge held");
        rd(ADR_STAT, 32'h30, 32'h10);
        stall <= 1'b0;
        wait_gates(4'h6, n);
        wait_gates(4'h3, n);
        chk(n, FAST_CLKS * OSC_DEF_CYC, "fast decay length");
        period(n);
        chk(n, CHOP_DIV * OSC_DEF_CYC, "default chop period");
        wr(ADR_DIV, 32'h10);
        fitted <= 1'b1;
        period(n);
        chk(n, CHOP_DIV * 16, "divided chop period");
        rd(ADR_STAT, 32'h8, 32'h8);
        fitted <= 1'b0;
        stall <= 1'b1;
        dir <= 1'b1;
        wr(ADR_CTRL, 32'h1);
        repeat (800) @(posedge clk_i);
        chk(g, 4'h6, "reverse charge held");
        stall <= 1'b0;
        wait_gates(4'h9, n);
        wait_gates(4'h3, n);
        dir <= 1'b0;
        wr(ADR_CTRL, 32'h0);
        fault_run(1'b0, OC_CYC);
        fault_run(1'b1, OT_CYC);
        wr(ADR_MASK, 32'h4);
        oc_f <= 1'b1;
        wait_flag(n);
        oc_f <= 1'b0;
        uv_f <= 1'b1;
        repeat (10) @(posedge clk_i);
        chk({g, oe_g}, 5'h01, "undervoltage off and reset");
        rd(ADR_STAT, 32'h4, 32'h4);
        chk(irq_o, 1'b1, "undervoltage interrupt");
        rd(ADR_IRQ, 32'h4, 32'h4);
        uv_f <= 1'b0;
        wait_gates(4'h9, n);
        close_out();
    end
endmodule
